// ===== pkg/pscl_pkg.sv
// Constants, types and register map of the passive serial configuration loader.
// Assumes a 10 MHz aclk and an AXI4-Lite master with an 8-bit byte address.
// Functional notes
// (RULE_01) User mode: request, status, load-complete all high
// (RULE_02) Request low abandons user mode, restarts configuration
// (RULE_03) Status held low during power-on delay
// (RULE_04) Load-complete low until configuration finishes
// (RULE_05) Host drives serial clock after configuration
// (RULE_06) Data pin becomes user I/O afterwards
// (RULE_07) Load-complete released only after full bitstream
// (RULE_08) Two falling serial edges start initialization
// (RULE_09) Init-done driven low until initialization ends
// (RULE_10) Load-complete low within 600 ns of request
// (RULE_11) Status low within 600 ns of request
// (RULE_12) Host holds request low at least 2 us
// (RULE_13) Status low pulse lasts 268 to 1506 us
// (RULE_14) Status released within 1506 us of request rising
// (RULE_15) Host waits before first rising serial edge
// (RULE_16) Data sampled on rising serial clock edges
// (RULE_17) Oscillator init: user mode 175-437 us later
// (RULE_18) Start-up clock enabled late, then 8576 cycles
// (RULE_19) Three initialization clock sources, 8576 cycles minimum
// (RULE_20) Host treats status low as error, restarts
`default_nettype none

package pscl_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ          = 10;
  localparam int T_CF2ST0_MAX_NS  = 600;
  localparam int CF2ST0_CYC       = T_CF2ST0_MAX_NS * CLK_MHZ / 1000;
  localparam int T_STATUS_MIN_US  = 268;
  localparam int STATUS_MIN_CYC   = T_STATUS_MIN_US * CLK_MHZ;
  localparam int T_CD2UM_MIN_US   = 175;
  localparam int T_CD2UM_MAX_US   = 437;
  localparam int OSC_INIT_CYC     = (T_CD2UM_MIN_US + T_CD2UM_MAX_US) / 2 * CLK_MHZ;
  localparam int T_SCLK_MIN_NS    = 8;
  localparam int CD2CU_CYC        = (4 * T_SCLK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_MIN_CYCLES  = 8576;
  localparam int POR_CYC          = 1000;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_LENGTH   = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_COUNT    = 8'h0c;
  localparam logic [7:0]  OFS_DATA     = 8'h10;
  localparam logic [31:0] CTRL_RST     = 32'h00000000;
  localparam logic [31:0] LENGTH_RST   = 32'h00000000;
  localparam int          CTRL_INIT_EN = 0;
  localparam int          CTRL_SRC_LSB = 1;
  localparam int          CTRL_IO_OE   = 4;
  localparam int          CTRL_IO_OUT  = 5;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {ST_POR, ST_RST_PULSE, ST_WAIT_REL, ST_LOAD,
                            ST_WAIT_EDGES, ST_INIT, ST_USER, ST_FAULT} pscl_state_t;
endpackage : pscl_pkg

`default_nettype wire

// ===== pkg/pscl_edge_if.sv
// Edge carrier between the edge finder and the loader core.
// Assumes producer and consumer share aclk.
`default_nettype none

interface pscl_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport prod (output level, rise, fall);
  modport cons (input level, rise, fall);
endinterface : pscl_edge_if

`default_nettype wire

// ===== core/pscl_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is an independent level.
`default_nettype none

module pscl_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,    // Clock
  input  wire logic         aresetn, // Sync reset, low
  input  wire logic         ce,      // Clock enable
  input  wire logic [W-1:0] d,       // Async inputs
  output var  logic [W-1:0] q        // Synchronised
);
  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg[i] <= 1'b0;
        q[i]        <= 1'b0;
      end else if (ce) begin
        meta_reg[i] <= d[i];
        q[i]        <= meta_reg[i];
      end
    end
  end
endmodule : pscl_sync

`default_nettype wire

// ===== core/pscl_edge.sv
// Edge finder on a synchronised clock level.
// Assumes the level is already synchronised to aclk.
`default_nettype none

module pscl_edge (
  input  wire logic aclk,    // Clock
  input  wire logic aresetn, // Sync reset, low
  input  wire logic ce,      // Clock enable
  input  wire logic level_s, // Synchronised level
  pscl_edge_if.prod edge_o   // Edge pulses
);
  logic prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= level_s;
    end
  end

  assign edge_o.level = level_s;
  assign edge_o.rise  = ce & level_s & ~prev_reg;
  assign edge_o.fall  = ce & ~level_s & prev_reg;
endmodule : pscl_edge

`default_nettype wire

// ===== core/pscl_loader.sv
// Passive serial configuration loader with AXI4-Lite control registers.
// Assumes open-drain status and load-complete lines pulled up outside.
`default_nettype none

module pscl_loader #(
  parameter int unsigned INIT_CYCLES = pscl_pkg::INIT_MIN_CYCLES
) (
  input  wire logic        aclk,                // Clock, 10 MHz
  input  wire logic        aresetn,             // Sync reset, low
  input  wire logic        ce,                  // Clock enable
  input  wire logic [7:0]  s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output var  logic        s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Byte strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output var  logic        s_axi_wready,        // Write data ready
  output var  logic [1:0]  s_axi_bresp,         // Write response
  output var  logic        s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [7:0]  s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output var  logic        s_axi_arready,       // Read address ready
  output var  logic [31:0] s_axi_rdata,         // Read data
  output var  logic [1:0]  s_axi_rresp,         // Read response
  output var  logic        s_axi_rvalid,        // Read valid
  input  wire logic        s_axi_rready,        // Read ready
  input  wire logic        config_request_n,    // Configuration request pin
  input  wire logic        serial_load_clock,   // Host serial clock
  input  wire logic        serial_load_bit_in,  // Data pin level
  output var  logic        serial_load_bit_out, // Data pin drive value
  output var  logic        serial_load_bit_oe,  // Data pin drive enable
  input  wire logic        status_n_in,         // Status line level
  output var  logic        status_n_out,        // Status drive value
  output var  logic        status_n_oe,         // Status pulled low
  output var  logic        load_complete_out,   // Load-complete drive value
  output var  logic        load_complete_oe,    // Load-complete pulled low
  input  wire logic        user_startup_clock,  // User start-up clock
  output var  logic        init_done_out,       // Init-done drive value
  output var  logic        init_done_oe         // Init-done pulled low
);
  // ****************************************
  // Pin synchronisers and edge finders
  // ****************************************
  logic [4:0]  pins_s;
  logic        req_s;
  logic        data_s;
  logic        stat_s;
  pscl_edge_if sclk_if ();
  pscl_edge_if uclk_if ();

  pscl_sync #(
    .W (5)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({user_startup_clock, status_n_in, serial_load_bit_in, serial_load_clock, config_request_n}),
    .q       (pins_s)
  );

  assign req_s  = pins_s[0];
  assign data_s = pins_s[2];
  assign stat_s = pins_s[3];

  pscl_edge u_sclk_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level_s (pins_s[1]),
    .edge_o  (sclk_if)
  );

  pscl_edge u_uclk_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level_s (pins_s[4]),
    .edge_o  (uclk_if)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_length;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [31:0] ctrl_reg;
  logic [31:0] length_reg;

  assign do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_ctrl   = do_write & (awaddr_reg == pscl_pkg::OFS_CTRL);
  assign wr_length = do_write & (awaddr_reg == pscl_pkg::OFS_LENGTH);
  assign wr_hit    = (awaddr_reg == pscl_pkg::OFS_CTRL) | (awaddr_reg == pscl_pkg::OFS_LENGTH) |
                     (awaddr_reg == pscl_pkg::OFS_STATUS) | (awaddr_reg == pscl_pkg::OFS_COUNT) |
                     (awaddr_reg == pscl_pkg::OFS_DATA);

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pscl_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? pscl_pkg::RESP_OKAY : pscl_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Byte-lane writes of the two writable registers
  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_reg[8*b +: 8]   <= pscl_pkg::CTRL_RST[8*b +: 8];
        length_reg[8*b +: 8] <= pscl_pkg::LENGTH_RST[8*b +: 8];
      end else if (ce) begin
        if (wr_ctrl && wstrb_reg[b]) begin
          ctrl_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
        end
        if (wr_length && wstrb_reg[b]) begin
          length_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
        end
      end
    end
  end

  // ****************************************
  // Loader state
  // ****************************************
  pscl_pkg::pscl_state_t state_reg;
  logic [31:0] tmr_reg;
  logic [31:0] icnt_reg;
  logic [31:0] bits_reg;
  logic [31:0] shift_reg;
  logic        edges_reg;
  logic        err_reg;
  logic        uclk_en_reg;
  logic [1:0]  src;

  assign src = ctrl_reg[pscl_pkg::CTRL_SRC_LSB +: 2];

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    unique case ({s_axi_araddr[7:2], 2'h0})
      pscl_pkg::OFS_CTRL:   rd_word = ctrl_reg;
      pscl_pkg::OFS_LENGTH: rd_word = length_reg;
      pscl_pkg::OFS_STATUS: rd_word = {24'h000000, (state_reg == pscl_pkg::ST_USER), err_reg, data_s,
                                       stat_s, ~load_complete_oe, state_reg};
      pscl_pkg::OFS_COUNT:  rd_word = bits_reg;
      pscl_pkg::OFS_DATA:   rd_word = shift_reg;
      default:              rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pscl_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? pscl_pkg::RESP_OKAY : pscl_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Configuration sequence
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= pscl_pkg::ST_POR;
      tmr_reg     <= 32'h00000000;
      icnt_reg    <= 32'h00000000;
      bits_reg    <= 32'h00000000;
      shift_reg   <= 32'h00000000;
      edges_reg   <= 1'b0;
      err_reg     <= 1'b0;
      uclk_en_reg <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        pscl_pkg::ST_POR: begin
          tmr_reg <= tmr_reg + 32'h00000001;
          if (tmr_reg >= 32'(pscl_pkg::POR_CYC - 1)) begin                 // [RULE_03]
            tmr_reg   <= 32'h00000000;
            state_reg <= req_s ? pscl_pkg::ST_WAIT_REL : pscl_pkg::ST_RST_PULSE;
          end
        end
        pscl_pkg::ST_RST_PULSE: begin
          if (tmr_reg < 32'(pscl_pkg::STATUS_MIN_CYC)) begin
            tmr_reg <= tmr_reg + 32'h00000001;
          end
          if (req_s && tmr_reg >= 32'(pscl_pkg::STATUS_MIN_CYC - 1)) begin   // [RULE_13] [RULE_14]
            state_reg <= pscl_pkg::ST_WAIT_REL;
          end
        end
        pscl_pkg::ST_WAIT_REL: begin
          if (stat_s) begin                                                 // [RULE_14]
            bits_reg  <= 32'h00000000;
            err_reg   <= 1'b0;
            state_reg <= pscl_pkg::ST_LOAD;
          end
        end
        pscl_pkg::ST_LOAD: begin
          if (!stat_s) begin
            err_reg   <= 1'b1;
            state_reg <= pscl_pkg::ST_FAULT;
          end else if (sclk_if.rise) begin                                  // [RULE_16]
            shift_reg <= {shift_reg[30:0], data_s};
            bits_reg  <= bits_reg + 32'h00000001;
            if (bits_reg + 32'h00000001 == length_reg) begin                // [RULE_07]
              edges_reg <= 1'b0;
              state_reg <= pscl_pkg::ST_WAIT_EDGES;
            end
          end
        end
        pscl_pkg::ST_WAIT_EDGES: begin
          if (sclk_if.fall) begin                                           // [RULE_08]
            edges_reg <= 1'b1;
            if (edges_reg) begin
              tmr_reg   <= 32'h00000000;
              icnt_reg  <= 32'h00000000;
              state_reg <= pscl_pkg::ST_INIT;
            end
          end
        end
        pscl_pkg::ST_INIT: begin
          if (src == 2'h1) begin
            if (!uclk_en_reg) begin
              tmr_reg <= tmr_reg + 32'h00000001;
              if (tmr_reg >= 32'(pscl_pkg::CD2CU_CYC - 1)) begin            // [RULE_18]
                uclk_en_reg <= 1'b1;
              end
            end else if (uclk_if.rise) begin
              icnt_reg <= icnt_reg + 32'h00000001;
              if (icnt_reg >= INIT_CYCLES - 1) begin                        // [RULE_18] [RULE_19]
                uclk_en_reg <= 1'b0;
                state_reg   <= pscl_pkg::ST_USER;
              end
            end
          end else if (src == 2'h2) begin
            if (sclk_if.rise) begin
              icnt_reg <= icnt_reg + 32'h00000001;
              if (icnt_reg >= INIT_CYCLES - 1) begin                        // [RULE_19]
                state_reg <= pscl_pkg::ST_USER;
              end
            end
          end else begin
            tmr_reg <= tmr_reg + 32'h00000001;
            if (tmr_reg >= 32'(pscl_pkg::OSC_INIT_CYC - 1)) begin           // [RULE_17]
              state_reg <= pscl_pkg::ST_USER;
            end
          end
        end
        pscl_pkg::ST_USER: begin
          tmr_reg <= 32'h00000000;
        end
        pscl_pkg::ST_FAULT: begin
          tmr_reg <= 32'h00000000;
        end
      endcase
      if (!req_s && state_reg != pscl_pkg::ST_POR && state_reg != pscl_pkg::ST_RST_PULSE) begin
        tmr_reg     <= 32'h00000000;                                        // [RULE_02]
        uclk_en_reg <= 1'b0;
        state_reg   <= pscl_pkg::ST_RST_PULSE;
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_n_out      <= 1'b0;
      status_n_oe       <= 1'b1;
      load_complete_out <= 1'b0;
      load_complete_oe  <= 1'b1;
    end else if (ce) begin
      status_n_out      <= 1'b0;
      status_n_oe       <= (state_reg == pscl_pkg::ST_POR) | (state_reg == pscl_pkg::ST_RST_PULSE) |
                           (state_reg == pscl_pkg::ST_FAULT);               // [RULE_03] [RULE_11] [RULE_01]
      load_complete_out <= 1'b0;
      load_complete_oe  <= (state_reg != pscl_pkg::ST_WAIT_EDGES) & (state_reg != pscl_pkg::ST_INIT) &
                           (state_reg != pscl_pkg::ST_USER);                // [RULE_04] [RULE_10] [RULE_01]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_load_bit_out <= 1'b0;
      serial_load_bit_oe  <= 1'b0;
      init_done_out       <= 1'b0;
      init_done_oe        <= 1'b0;
    end else if (ce) begin
      serial_load_bit_out <= ctrl_reg[pscl_pkg::CTRL_IO_OUT];
      serial_load_bit_oe  <= (state_reg == pscl_pkg::ST_USER) & ctrl_reg[pscl_pkg::CTRL_IO_OE]; // [RULE_06]
      init_done_out       <= 1'b0;
      init_done_oe        <= ctrl_reg[pscl_pkg::CTRL_INIT_EN] &
                             ((state_reg == pscl_pkg::ST_WAIT_EDGES) | (state_reg == pscl_pkg::ST_INIT)); // [RULE_09]
    end
  end
endmodule : pscl_loader

`default_nettype wire

// ===== sim/pscl_host_model.sv
// Host model: request pulse, serial clock and data, open-drain wire levels.
// Assumes a 10 MHz aclk and a pulled-up status wire.
`default_nettype none

module pscl_host_model (
  input  wire logic aclk,                // Clock
  input  wire logic status_n_oe,         // Device pulls status low
  input  wire logic serial_load_bit_out, // Device data value
  input  wire logic serial_load_bit_oe,  // Device data enable
  output var  logic config_request_n,    // Request pin
  output var  logic serial_load_clock,   // Serial clock
  output var  logic serial_load_bit_in,  // Data wire level
  output var  logic status_n_in          // Status wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_bit;
  logic hold_low;
  // ****************************************
  // Pins and host sequences
  // ****************************************
  initial begin
    config_request_n = 1'b1;
    serial_load_clock = 1'b0; // Driven, never floating
    host_bit = 1'b0;
    hold_low = 1'b0;
  end
  assign status_n_in = !(status_n_oe || hold_low);
  assign serial_load_bit_in = serial_load_bit_oe ? serial_load_bit_out : host_bit;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc
  // Request held low 2 us
  task automatic request();
    @(posedge aclk);
    config_request_n <= 1'b0;
    wait_cyc(20);
    config_request_n <= 1'b1;
  endtask : request
  // Status high, then 2 us before the first rise
  task automatic wait_ready();
    do @(posedge aclk); while (status_n_in !== 1'b1);
    wait_cyc(20);
  endtask : wait_ready
  // 800 ns period, data set while low
  task automatic pulse(input logic b);
    serial_load_clock <= 1'b0;
    host_bit <= b;
    wait_cyc(4);
    serial_load_clock <= 1'b1;
    wait_cyc(4);
  endtask : pulse
  // Holds the status wire low from outside
  task automatic hold(input int n);
    hold_low <= 1'b1;
    wait_cyc(n);
    hold_low <= 1'b0;
  endtask : hold
endmodule : pscl_host_model

`default_nettype wire

// ===== sim/pscl_loader_monitor.sv
// Checker of the loader's configuration pin timing.
// Assumes a 10 MHz aclk; bound to every pscl_loader.
`default_nettype none

module pscl_loader_monitor (
  input wire logic aclk,               // Clock
  input wire logic aresetn,            // Sync reset, low
  input wire logic config_request_n,   // Request pin
  input wire logic status_n_oe,        // Status pulled low
  input wire logic load_complete_oe,   // Load-complete pulled low
  input wire logic init_done_oe,       // Init-done pulled low
  input wire logic serial_load_bit_oe  // Data drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STAT_MAX_CYC = 15060;
  int unsigned por_cnt;
  int unsigned stat_cnt;
  int unsigned rel_cnt;
  logic        req_seen;
  // ****************************************
  // Helper counters
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) por_cnt <= 0;
    else if (por_cnt < 32'h0000ffff) por_cnt <= por_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !status_n_oe) stat_cnt <= 0;
    else stat_cnt <= stat_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !status_n_oe || !config_request_n) rel_cnt <= 0;
    else rel_cnt <= rel_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !status_n_oe) req_seen <= 1'b0;
    else if (!config_request_n) req_seen <= 1'b1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  req_low_a: assert property (
    $fell(config_request_n) |-> ##[0:6] (status_n_oe && load_complete_oe)) else $error("request fall unanswered");
  por_hold_a: assert property (
    por_cnt < pscl_pkg::POR_CYC |-> status_n_oe) else $error("status released in power-on delay");
  stat_min_a: assert property (
    $fell(status_n_oe) && req_seen |-> stat_cnt >= pscl_pkg::STATUS_MIN_CYC) else $error("status pulse short");
  stat_max_a: assert property (
    rel_cnt <= STAT_MAX_CYC) else $error("status held too long");
  user_lines_a: assert property (
    !load_complete_oe |-> !status_n_oe) else $error("status low while load released");
  done_keep_a: assert property (
    !load_complete_oe && config_request_n |=> !load_complete_oe) else $error("load-complete pulled low again");
  init_low_a: assert property (
    init_done_oe |-> !load_complete_oe && !status_n_oe) else $error("init-done low early");
  user_io_a: assert property (
    serial_load_bit_oe |-> !load_complete_oe && !init_done_oe && !status_n_oe) else $error("data pin driven early");
endmodule : pscl_loader_monitor

bind pscl_loader pscl_loader_monitor u_mon (.aclk, .aresetn, .config_request_n, .status_n_oe, .load_complete_oe,
  .init_done_oe, .serial_load_bit_oe);

`default_nettype wire

// ===== sim/pscl_loader_tb.sv
// Loader bench: AXI4-Lite register access and host-driven loads.
// Assumes package, loader, host model and checker compiled first.
`default_nettype none

module pscl_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         INIT_N   = 16;
  localparam logic [7:0] CFG_BYTE = 8'ha5;
  logic        aclk, aresetn, ce, user_startup_clock;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        config_request_n, serial_load_clock, serial_load_bit_in, serial_load_bit_out, serial_load_bit_oe;
  logic        status_n_in, status_n_out, status_n_oe, load_complete_out, load_complete_oe;
  logic        init_done_out, init_done_oe;
  int          n_errors, compares, cyc, t_rel, t_usr;
  int          lo [2] = '{1750, 54};
  int          hi [2] = '{4370, 200};
  pscl_loader #(.INIT_CYCLES(INIT_N)) dut (.*);
  pscl_host_model host (.*);
  // ****************************************
  // Clocks, timestamps and tasks
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    user_startup_clock = 1'b0;
    forever #173 user_startup_clock = ~user_startup_clock;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if ($fell(load_complete_oe)) t_rel <= cyc;
    if ($fell(init_done_oe)) t_usr <= cyc;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pscl_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er = pscl_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata & m, e);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : axi_rd
  task automatic edges(input int n);
    repeat (n) host.pulse(1'b0);
  endtask : edges
  // Sets the source, requests, loads one byte of LENGTH 8
  task automatic cfg_load(input logic [1:0] src);
    axi_wr(pscl_pkg::OFS_CTRL, 32'h31 | {29'h0, src, 1'b0});
    axi_rd(pscl_pkg::OFS_CTRL, '1, 32'h31 | {29'h0, src, 1'b0});
    host.wait_ready();
    host.request();
    host.wait_ready();
    for (int i = 7; i > 0; i--) host.pulse(CFG_BYTE[i]);
    chk("done_early", {31'h0, load_complete_oe}, 32'h1);
    axi_rd(pscl_pkg::OFS_COUNT, '1, 32'h7);
    host.pulse(CFG_BYTE[0]);
    host.wait_cyc(4);
    chk("done_oe", {30'h0, load_complete_oe, init_done_oe}, 32'h1);
    axi_rd(pscl_pkg::OFS_DATA, 32'hff, {24'h0, CFG_BYTE});
  endtask : cfg_load
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #5000000;
    n_errors++;
    end_sim();
  end
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("por_lines", {30'h0, status_n_oe, load_complete_oe}, 32'h3);
    axi_rd(pscl_pkg::OFS_CTRL, '1, pscl_pkg::CTRL_RST);
    axi_rd(pscl_pkg::OFS_LENGTH, '1, pscl_pkg::LENGTH_RST);
    axi_wr(pscl_pkg::OFS_STATUS, 32'h7);
    axi_rd(pscl_pkg::OFS_STATUS, 32'h7, 32'h0);
    axi_wr(8'h14, 32'h1, pscl_pkg::RESP_SLVERR);
    axi_rd(8'h14, '1, 32'h0, pscl_pkg::RESP_SLVERR);
    s_axi_wstrb <= 4'h1;
    axi_wr(pscl_pkg::OFS_LENGTH, 32'hffffff08);
    cfg_load(2'h2);
    edges(INIT_N);
    ce <= 1'b0;
    edges(1);
    ce <= 1'b1;
    host.wait_cyc(4);
    axi_rd(pscl_pkg::OFS_STATUS, 32'h87, 32'h05);
    edges(1);
    host.wait_cyc(4);
    axi_rd(pscl_pkg::OFS_STATUS, 32'h87, 32'h86);
    chk("user_pins", {28'h0, status_n_oe, load_complete_oe, init_done_oe, serial_load_bit_oe}, 32'h1);
    chk("user_io", {31'h0, serial_load_bit_in}, 32'h1);
    host.request();
    host.wait_ready();
    for (int i = 0; i < 3; i++) host.pulse(1'b1);
    host.hold(10);
    axi_rd(pscl_pkg::OFS_STATUS, 32'h47, 32'h47);
    host.request();
    host.wait_ready();
    axi_rd(pscl_pkg::OFS_STATUS, 32'h47, 32'h03);
    for (int s = 0; s < 2; s++) begin
      cfg_load(2'(s));
      edges(2);
      for (int i = 0; i < 5000 && init_done_oe === 1'b1; i++) @(posedge aclk);
      host.wait_cyc(2);
      chk("init_time", {31'h0, (t_usr - t_rel) inside {[lo[s]:hi[s]]}}, 32'h1);
    end
    end_sim();
  end
endmodule : pscl_loader_tb

`default_nettype wire
